/* logic/eapc_pkg.sv */
// constants shared by the ext-line / pin-change interrupt block
package eapc_pkg;

   // ------------------------------
   // sizes
   // ------------------------------
   localparam int unsigned NL   = 4;   // dedicated lines
   localparam int unsigned NG   = 4;   // pin-change groups
   localparam int unsigned GW   = 8;   // inputs per group
   localparam int unsigned NSRC = NL + NG;
   localparam int unsigned VW   = $clog2(NSRC);
   localparam int unsigned AW   = 12;  // apb address width

   // ------------------------------
   // register indices (byte address = 4 * index)
   // ------------------------------
   localparam logic [7:0] IDX_REDIRECT = 8'h1a;
   localparam logic [7:0] IDX_PC_FLAGS = 8'h1b;
   localparam logic [7:0] IDX_EXT_FLAGS = 8'h1c;
   localparam logic [7:0] IDX_EXT_EN   = 8'h1d;
   localparam logic [7:0] IDX_PC_EN    = 8'h68;
   localparam logic [7:0] IDX_SENSE    = 8'h69;
   localparam logic [7:0] IDX_MASK0    = 8'h6b;
   localparam logic [7:0] IDX_MASK1    = 8'h6c;
   localparam logic [7:0] IDX_MASK2    = 8'h6d;
   localparam logic [7:0] IDX_GLOBAL   = 8'h70;
   localparam logic [7:0] IDX_MASK3    = 8'h73;

   // ------------------------------
   // fields and reset values
   // ------------------------------
   localparam int unsigned RDR_LSB   = 2;     // redirect bits 3..2
   localparam int unsigned GIE_BIT   = 0;     // global enable bit
   localparam logic [3:0] PCF_WMASK  = 4'h7;  // group-3 flag is read only
   localparam logic [7:0] RST_REG    = 8'h00;

   // sense codes
   localparam logic [1:0] SNS_LOW  = 2'h0;
   localparam logic [1:0] SNS_ANY  = 2'h1;
   localparam logic [1:0] SNS_FALL = 2'h2;
   localparam logic [1:0] SNS_RISE = 2'h3;

   // word index from a byte address
   function automatic logic [7:0] reg_idx(input logic [AW-1:0] a);
      return a[9:2];
   endfunction

endpackage

/* logic/eapc_det_if.sv */
// bundle between an input detector and its user
`timescale 1ns/10ps
interface eapc_det_if #(parameter int unsigned W = 4);
   logic [W-1:0] raw;   // unsynchronised level in
   logic [W-1:0] lvl;   // synchronised level
   logic [W-1:0] rise;  // one-cycle rising change
   logic [W-1:0] fall;  // one-cycle falling change
   modport det (input raw, output lvl, rise, fall);
   modport usr (output raw, input lvl, rise, fall);
endinterface

/* logic/eapc_sync_det.sv */
// two-flop synchroniser with previous-sample change detection
`timescale 1ns/10ps
module eapc_sync_det #(
   parameter int unsigned W = 4
) (
   input wire logic  pclk,
   input wire logic  presetn,
   input wire logic  pclk_en,
   eapc_det_if.det   d
);

   // ------------------------------
   // state
   // ------------------------------
   typedef struct packed {
      logic [W-1:0] s1;    // first stage, read by s2 only
      logic [W-1:0] s2;    // settled level
      logic [W-1:0] prev;  // level one clock earlier
      logic [1:0]   fill;  // counts stages filled after reset
   } eapc_det_st_t;

   eapc_det_st_t q;
   eapc_det_st_t n;

   // shift the samples while enabled
   always_comb begin
      n = q;
      if (pclk_en) begin
         n.s1   = d.raw;
         n.s2   = q.s1;
         n.prev = q.s2;
         if (q.fill != 2'h3) begin
            n.fill = q.fill + 2'h1;
         end
      end
   end

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // no edges until prev holds a real sample, else a high pin
   // after reset would look like a change
   assign d.lvl  = q.s2;
   assign d.rise = (q.fill == 2'h3) ? (q.s2 & ~q.prev) : '0;  // [RL18]
   assign d.fall = (q.fill == 2'h3) ? (~q.s2 & q.prev) : '0;  // [RL18]

   property p_det_change;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && q.fill == 2'h3) |=> ((d.rise | d.fall) == ($past(q.s1) ^ $past(q.s2)));
   endproperty
   a_det_change: assert property (p_det_change) else $error("change not flagged"); // [RL18]

endmodule

/* logic/eapc_prio.sv */
// fixed-priority pick, lowest index wins
`timescale 1ns/10ps
module eapc_prio #(
   parameter int unsigned N = 8
) (
   input wire logic [N-1:0]         pend,
   output logic                     any,
   output logic [$clog2(N)-1:0]     idx
);

   // scan from the top so the lowest pending index is kept
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            any = 1'b1;
            idx = ($clog2(N))'(i);
         end
      end
   end

endmodule

/* logic/eapc_top.sv */
// ext-line and pin-change interrupt controller with apb slave
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps

// Contract
// [RL1] line enabled by its bit and global enable
// [RL2] pin activity counts even as output
// [RL3] line event sets its flag
// [RL4] taken line vectors, flag cleared on entry
// [RL5] writing one clears a flag; the group-3 flag ignores writes (PCF_WMASK)
// [RL6] low-level mode holds line flag cleared
// [RL7] sleep with lines off cuts input buffers
// [RL8] redirect bit picks line three pin
// [RL9] redirect bit picks line two pin
// [RL10] group k covers 8k..8k+7, enabled with global
// [RL11] each group has its own vector
// [RL12] change on enabled input sets group flag
// [RL13] taken group vectors, flag cleared on entry
// [RL14] per-input mask gates each input
// [RL15] two sense bits choose level or edge
// [RL16] low level keeps requesting while low
// [RL17] pin changes detected for wake-up
// [RL18] change equals sample differing from previous
module eapc_top (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  pclk_en,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   input wire logic [3:0]            ext_line_pins,
   input wire logic                  line_two_alternate_pin,
   input wire logic                  line_three_alternate_pin,
   input wire logic [31:0]           change_sensed_inputs,
   input wire logic                  sleep_req,
   input wire logic                  irq_ack,
   output logic                      irq,
   output logic [2:0]                irq_vector,
   output logic [3:0]                ext_line_buffer_off
);

   localparam int unsigned NL = eapc_pkg::NL;
   localparam int unsigned NG = eapc_pkg::NG;
   localparam int unsigned GW = eapc_pkg::GW;
   localparam int unsigned VW = eapc_pkg::VW;

   // ------------------------------
   // state
   // ------------------------------
   typedef struct packed {
      logic [1:0]       rdr;    // line source selects
      logic [NG-1:0]    pcf;    // group flags
      logic [NL-1:0]    ef;     // line flags
      logic [NL-1:0]    een;    // line enables
      logic [NG-1:0]    pcen;   // group enables
      logic [2*NL-1:0]  sense;  // two bits per line
      logic [NG*GW-1:0] mask;   // per-input masks
      logic             gie;    // global enable
      logic             irq;    // request out
      logic [VW-1:0]    vec;    // vector id out
      logic [NL-1:0]    boff;   // input buffers off
      logic [7:0]       rdat;   // read data
      logic             rdy;    // apb ready
      logic             err;    // apb error
   } eapc_top_st_t;

   eapc_top_st_t q;
   eapc_top_st_t n;

   // ------------------------------
   // helpers
   // ------------------------------
   logic [7:0]        idx;       // decoded word index
   logic              wr;        // write completes this edge
   logic              setup;     // apb setup cycle
   logic [7:0]        rd;        // read mux
   logic              hit;       // address mapped
   logic [NL-1:0]     w1c_ef;    // software clears, lines
   logic [NG-1:0]     w1c_pc;    // software clears, groups
   logic [NL-1:0]     ack_ext;   // entry clears, lines
   logic [NG-1:0]     ack_pc;    // entry clears, groups
   logic [NL-1:0]     ext_sel;   // chosen line pins
   logic [NL-1:0]     ext_set;   // line events
   logic [NG-1:0]     pc_set;    // group events
   logic [NG*GW-1:0]  pc_chg;    // any change per input
   logic [NL+NG-1:0]  pend;      // requests to arbitrate
   logic              any;       // something pending
   logic [VW-1:0]     pick;      // winning source

   // sense decode, used by flags and requests
   function automatic logic is_low(input logic [1:0] s);
      return s == eapc_pkg::SNS_LOW;
   endfunction

   function automatic logic sense_hit(input logic [1:0] s, input logic r, input logic f);
      logic h;
      h = 1'b0;
      unique case (s)  // [RL15]
         eapc_pkg::SNS_LOW:  h = 1'b0;
         eapc_pkg::SNS_ANY:  h = r | f;
         eapc_pkg::SNS_FALL: h = f;
         eapc_pkg::SNS_RISE: h = r;
      endcase
      return h;
   endfunction

   // ------------------------------
   // pin paths
   // ------------------------------
   eapc_det_if #(.W(NL))      ext_if ();
   eapc_det_if #(.W(NG * GW)) pc_if ();

   // pins are read raw whatever their port direction, so
   // software can raise a request by driving them
   always_comb begin
      ext_sel    = ext_line_pins;  // [RL2]
      ext_sel[2] = q.rdr[0] ? line_two_alternate_pin : ext_line_pins[2];    // [RL9]
      ext_sel[3] = q.rdr[1] ? line_three_alternate_pin : ext_line_pins[3];  // [RL8]
   end

   // a disabled input buffer reads low; that change may flag
   assign ext_if.raw = ext_sel & ~q.boff;  // [RL7]
   assign pc_if.raw  = change_sensed_inputs;

   // synchronous stand-in for the async detectors: only sees pulses
   // that span an enabled clock edge, needs the clock running
   eapc_sync_det #(.W(NL)) u_ext_det (
      .pclk    (pclk),
      .presetn (presetn),
      .pclk_en (pclk_en),
      .d       (ext_if.det)
   );

   eapc_sync_det #(.W(NG * GW)) u_pc_det (  // [RL17]
      .pclk    (pclk),
      .presetn (presetn),
      .pclk_en (pclk_en),
      .d       (pc_if.det)
   );

   assign pc_chg = pc_if.rise | pc_if.fall;

   // ------------------------------
   // events and requests
   // ------------------------------
   for (genvar i = 0; i < NL; i++) begin : g_line
      assign ext_set[i] = sense_hit(q.sense[2*i +: 2], ext_if.rise[i], ext_if.fall[i]);  // [RL3]
      // level mode asks straight from the pin, edge modes from the flag
      assign pend[i] = q.gie & q.een[i]  // [RL1]
                       & (is_low(q.sense[2*i +: 2]) ? ~ext_if.lvl[i] : q.ef[i]);  // [RL16]
   end

   for (genvar k = 0; k < NG; k++) begin : g_grp
      // group k owns inputs 8k..8k+7
      assign pc_set[k] = q.pcen[k] & (|(pc_chg[k*GW +: GW] & q.mask[k*GW +: GW]));  // [RL12] [RL14]
      assign pend[NL+k] = q.gie & q.pcen[k] & q.pcf[k];  // [RL10]
   end

   // vector ids 0..3 lines, 4..7 groups
   eapc_prio #(.N(NL + NG)) u_prio (  // [RL11]
      .pend (pend),
      .any  (any),
      .idx  (pick)
   );

   // ------------------------------
   // register read mux
   // ------------------------------
   always_comb begin
      rd  = 8'h00;
      hit = 1'b1;
      case (idx)
         eapc_pkg::IDX_REDIRECT:  rd[eapc_pkg::RDR_LSB +: 2] = q.rdr;
         eapc_pkg::IDX_PC_FLAGS:  rd[NG-1:0] = q.pcf;
         eapc_pkg::IDX_EXT_FLAGS: rd[NL-1:0] = q.ef;
         eapc_pkg::IDX_EXT_EN:    rd[NL-1:0] = q.een;
         eapc_pkg::IDX_PC_EN:     rd[NG-1:0] = q.pcen;
         eapc_pkg::IDX_SENSE:     rd = q.sense;
         eapc_pkg::IDX_MASK0:     rd = q.mask[0*GW +: GW];
         eapc_pkg::IDX_MASK1:     rd = q.mask[1*GW +: GW];
         eapc_pkg::IDX_MASK2:     rd = q.mask[2*GW +: GW];
         eapc_pkg::IDX_MASK3:     rd = q.mask[3*GW +: GW];
         eapc_pkg::IDX_GLOBAL:    rd[eapc_pkg::GIE_BIT] = q.gie;
         default:                 hit = 1'b0;  // unmapped
      endcase
   end

   // ------------------------------
   // next state
   // ------------------------------
   always_comb begin
      n       = q;
      idx     = eapc_pkg::reg_idx(paddr);
      setup   = psel & ~penable;
      wr      = psel & penable & q.rdy & pwrite;
      w1c_ef  = '0;
      w1c_pc  = '0;
      ack_ext = '0;
      ack_pc  = '0;
      // entry clears the flag of the vector shown
      for (int i = 0; i < NL; i++) begin
         ack_ext[i] = irq_ack & q.irq & (q.vec == VW'(i));  // [RL4]
      end
      for (int k = 0; k < NG; k++) begin
         ack_pc[k] = irq_ack & q.irq & (q.vec == VW'(NL + k));  // [RL13]
      end
      if (pclk_en) begin
         // zero-wait answer: ready in the first access cycle
         n.rdy = setup;
         n.err = setup & ~hit;
         if (setup) begin
            n.rdat = rd;
         end
         if (wr) begin
            case (idx)
               eapc_pkg::IDX_REDIRECT:  n.rdr = pwdata[eapc_pkg::RDR_LSB +: 2];
               eapc_pkg::IDX_PC_FLAGS:  w1c_pc = pwdata[NG-1:0] & eapc_pkg::PCF_WMASK;  // [RL5]
               eapc_pkg::IDX_EXT_FLAGS: w1c_ef = pwdata[NL-1:0];  // [RL5]
               eapc_pkg::IDX_EXT_EN:    n.een = pwdata[NL-1:0];
               eapc_pkg::IDX_PC_EN:     n.pcen = pwdata[NG-1:0];
               eapc_pkg::IDX_SENSE:     n.sense = pwdata[7:0];
               eapc_pkg::IDX_MASK0:     n.mask[0*GW +: GW] = pwdata[GW-1:0];
               eapc_pkg::IDX_MASK1:     n.mask[1*GW +: GW] = pwdata[GW-1:0];
               eapc_pkg::IDX_MASK2:     n.mask[2*GW +: GW] = pwdata[GW-1:0];
               eapc_pkg::IDX_MASK3:     n.mask[3*GW +: GW] = pwdata[GW-1:0];
               eapc_pkg::IDX_GLOBAL:    n.gie = pwdata[eapc_pkg::GIE_BIT];
               default:                 w1c_ef = '0;  // unmapped: write dropped, error stands one cycle
            endcase
         end
         // set wins over any clear in the same edge
         n.ef  = (q.ef & ~w1c_ef & ~ack_ext) | ext_set;
         n.pcf = (q.pcf & ~w1c_pc & ~ack_pc) | pc_set;
         for (int i = 0; i < NL; i++) begin
            if (is_low(q.sense[2*i +: 2])) begin
               n.ef[i] = 1'b0;  // [RL6]
            end
         end
         // buffers off only for lines that cannot interrupt
         n.boff = sleep_req ? ~(q.een & {NL{q.gie}}) : '0;  // [RL7]
         n.irq  = any;
         n.vec  = pick;
      end
   end

   // ------------------------------
   // registers
   // ------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // ------------------------------
   // outputs, all from flops
   // ------------------------------
   assign prdata              = {24'h000000, q.rdat};
   assign pready              = q.rdy;
   assign pslverr             = q.err;
   assign irq                 = q.irq;
   assign irq_vector          = q.vec;
   assign ext_line_buffer_off = q.boff;

   // ------------------------------
   // checks
   // ------------------------------
   property p_gie_off;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && !q.gie) |=> !irq;
   endproperty
   a_gie_off: assert property (p_gie_off) else $error("irq with global enable off"); // [RL1]

   property p_line_set;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && ext_set[0]) |=> q.ef[0];
   endproperty
   a_line_set: assert property (p_line_set) else $error("line flag not set"); // [RL3]

   property p_line_ack;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && irq_ack && q.irq && q.vec == 3'h0 && !ext_set[0]) |=> !q.ef[0];
   endproperty
   a_line_ack: assert property (p_line_ack) else $error("entry did not clear line flag"); // [RL4]

   property p_w1c;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && wr && idx == eapc_pkg::IDX_EXT_FLAGS && pwdata[1] && !ext_set[1]) |=> !q.ef[1];
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear"); // [RL5]

   property p_low_clr;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && q.sense[5:4] == eapc_pkg::SNS_LOW) |=> !q.ef[2];
   endproperty
   a_low_clr: assert property (p_low_clr) else $error("level-mode flag set"); // [RL6]

   property p_sleep_buf;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && sleep_req && !q.een[1]) |=> ext_line_buffer_off[1];
   endproperty
   a_sleep_buf: assert property (p_sleep_buf) else $error("buffer left on in sleep"); // [RL7]

   property p_level_req;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && q.gie && q.een[0] && q.sense[1:0] == eapc_pkg::SNS_LOW && !ext_if.lvl[0]) |=> irq;
   endproperty
   a_level_req: assert property (p_level_req) else $error("low level not requesting"); // [RL16]

   property p_mask_gate;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && !q.pcf[0] && (pc_chg[7:0] & q.mask[7:0]) == 8'h00) |=> !q.pcf[0];
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("masked input set flag"); // [RL14]

   property p_grp_ack;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && irq_ack && q.irq && q.vec == 3'h4 && !pc_set[0]) |=> !q.pcf[0];
   endproperty
   a_grp_ack: assert property (p_grp_ack) else $error("entry did not clear group flag"); // [RL13]

   property p_grp_set;
      @(posedge pclk) disable iff (!presetn)
      (pclk_en && pc_set[1]) |=> q.pcf[1] ##1 (irq || !(q.gie && q.pcen[1]) || $past(irq_ack));
   endproperty
   a_grp_set: assert property (p_grp_set) else $error("group change lost"); // [RL12]

endmodule

/* dv/eapc_pin_model.sv */
// pin-side model: board logic driving line, alternate and pin-change inputs
`timescale 1ns/10ps
module eapc_pin_model (
   input wire logic    pclk,
   output logic [3:0]  line_pins,
   output logic [1:0]  alt_pins,
   output logic [31:0] pc_pins
);
   // ------------------------------
   // idle levels
   // ------------------------------
   // all pins rest high so low-level sensing stays quiet by default
   initial begin
      line_pins = 4'hf;
      alt_pins  = 2'h3;
      pc_pins   = 32'hffff_ffff;
   end

   // ------------------------------
   // stimulus tasks
   // ------------------------------
   // two toggles held 5 clocks each; pulses under one clock may be missed
   // sel 0 line pin n, 1 alternate pin of line n (2 or 3), 2 pin-change n
   task automatic pulse(input int sel, input int n);
      repeat (2) begin
         @(posedge pclk);
         case (sel)
            0: line_pins[n] <= ~line_pins[n];
            1: alt_pins[n-2] <= ~alt_pins[n-2];
            default: pc_pins[n] <= ~pc_pins[n];
         endcase
         repeat (4) @(posedge pclk);
      end
   endtask

   // steady level on one line pin
   task automatic set_line(input int n, input logic v);
      @(posedge pclk);
      line_pins[n] <= v;
   endtask
endmodule

/* dv/ext_and_pin_change_irq_tb_top.sv */
// self-checking bench for the ext-line and pin-change interrupt block
`timescale 1ns/10ps
module ext_and_pin_change_irq_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  line_pins, buf_off;
   logic [1:0]  alt_pins;
   logic [31:0] pc_pins;
   logic        sleep_req, irq_ack, irq, pclk_en;
   logic [2:0]  irq_vector;
   int          mismatches, samples_checked, cycles;

   // ------------------------------
   // instances
   // ------------------------------
   eapc_top u_eapc_top (
      .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_line_pins(line_pins), .line_two_alternate_pin(alt_pins[0]),
      .line_three_alternate_pin(alt_pins[1]), .change_sensed_inputs(pc_pins),
      .sleep_req(sleep_req), .irq_ack(irq_ack), .irq(irq), .irq_vector(irq_vector),
      .ext_line_buffer_off(buf_off));
   eapc_pin_model u_eapc_pin_model (
      .pclk(pclk), .line_pins(line_pins), .alt_pins(alt_pins), .pc_pins(pc_pins));

   // ------------------------------
   // clock and hang guard
   // ------------------------------
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // whole run needs a few hundred cycles; the ceiling leaves margin
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   // ------------------------------
   // helpers
   // ------------------------------
   task automatic complete_run();
      if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, idx, {24'h0, v}, rd, err);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, idx, 32'h0, rd, err);
      check(what, rd, {24'h0, exp});
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // bounded wait for the request, then its vector id
   task automatic wait_irq(input logic [2:0] vec);
      for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge pclk);
      check("irq", irq, 1'b1);
      check("irq_vector", irq_vector, vec);
   endtask
   // one-cycle vector entry, then three cycles where the note asks for two
   task automatic ack();
      @(posedge pclk);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      wait_clk(3);
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_regs();
      logic [7:0]  idx [8];
      logic [31:0] rd;
      logic        err;
      idx = '{eapc_pkg::IDX_REDIRECT, eapc_pkg::IDX_PC_FLAGS, eapc_pkg::IDX_EXT_FLAGS,
              eapc_pkg::IDX_PC_EN, eapc_pkg::IDX_MASK0, eapc_pkg::IDX_MASK1,
              eapc_pkg::IDX_MASK2, eapc_pkg::IDX_MASK3};
      foreach (idx[i]) rd_chk("reset value", idx[i], 8'h00);
      wr(eapc_pkg::IDX_REDIRECT, 8'hff);
      rd_chk("redirect rw bits", eapc_pkg::IDX_REDIRECT, 8'h0c);
      wr(eapc_pkg::IDX_REDIRECT, 8'h00);
      wr(eapc_pkg::IDX_MASK1, 8'hff);
      rd_chk("mask1", eapc_pkg::IDX_MASK1, 8'hff);
      wr(eapc_pkg::IDX_MASK1, 8'h00);
      apb(1'b0, 8'h00, 32'h0, rd, err);
      check("unmapped read", rd, 32'h0);
      check("unmapped error", err, 1'b1);
      apb(1'b1, 8'h00, 32'hff, rd, err);
      check("unmapped write error", err, 1'b1);
      @(posedge pclk);
      check("error for one cycle", pslverr, 1'b0);
   endtask
   // rising edge on line 0, gated by global enable, cleared on entry
   task automatic t_line_edge();
      wr(eapc_pkg::IDX_SENSE, 8'h03);
      wr(eapc_pkg::IDX_EXT_EN, 8'h01);
      u_eapc_pin_model.pulse(0, 0);
      rd_chk("line flag", eapc_pkg::IDX_EXT_FLAGS, 8'h01);
      check("irq without global", irq, 1'b0);
      wr(eapc_pkg::IDX_GLOBAL, 8'h01);
      wait_irq(3'h0);
      ack();
      rd_chk("flag after entry", eapc_pkg::IDX_EXT_FLAGS, 8'h00);
      check("irq after entry", irq, 1'b0);
   endtask
   // falling edge on disabled line 1, write-one-to-clear
   task automatic t_w1c();
      wr(eapc_pkg::IDX_EXT_EN, 8'h00);
      wr(eapc_pkg::IDX_SENSE, 8'h08);
      u_eapc_pin_model.pulse(0, 1);
      rd_chk("falling flag", eapc_pkg::IDX_EXT_FLAGS, 8'h02);
      check("irq line disabled", irq, 1'b0);
      wr(eapc_pkg::IDX_EXT_FLAGS, 8'h00);
      rd_chk("write zero keeps", eapc_pkg::IDX_EXT_FLAGS, 8'h02);
      wr(eapc_pkg::IDX_EXT_FLAGS, 8'h02);
      rd_chk("write one clears", eapc_pkg::IDX_EXT_FLAGS, 8'h00);
   endtask
   // low level on line 2 requests while low, flag stays clear
   task automatic t_level();
      wr(eapc_pkg::IDX_SENSE, 8'h00);
      wr(eapc_pkg::IDX_EXT_EN, 8'h04);
      u_eapc_pin_model.set_line(2, 1'b0);
      wait_irq(3'h2);
      rd_chk("level flag", eapc_pkg::IDX_EXT_FLAGS, 8'h00);
      ack();
      check("level still requests", irq, 1'b1);
      u_eapc_pin_model.set_line(2, 1'b1);
      wait_clk(6);
      check("level released", irq, 1'b0);
      wr(eapc_pkg::IDX_EXT_EN, 8'h00);
   endtask
   // only the selected source of lines 2 and 3 sets the flag
   task automatic t_redirect();
      for (int n = 2; n < 4; n++) begin
         wr(eapc_pkg::IDX_SENSE, 8'(8'h01 << (2 * n)));
         u_eapc_pin_model.pulse(1, n);
         rd_chk("alt inactive", eapc_pkg::IDX_EXT_FLAGS, 8'h00);
         wr(eapc_pkg::IDX_REDIRECT, 8'(8'h01 << n));
         u_eapc_pin_model.pulse(1, n);
         rd_chk("alt active", eapc_pkg::IDX_EXT_FLAGS, 8'(8'h01 << n));
         wr(eapc_pkg::IDX_EXT_FLAGS, 8'(8'h01 << n));
         u_eapc_pin_model.pulse(0, n);
         rd_chk("primary inactive", eapc_pkg::IDX_EXT_FLAGS, 8'h00);
         wr(eapc_pkg::IDX_REDIRECT, 8'h00);
      end
   endtask
   // each group: masked pin quiet, unmasked pin flags, own vector
   task automatic t_groups();
      logic [7:0] msk [4];
      msk = '{eapc_pkg::IDX_MASK0, eapc_pkg::IDX_MASK1, eapc_pkg::IDX_MASK2, eapc_pkg::IDX_MASK3};
      wr(eapc_pkg::IDX_MASK0, 8'h80);
      u_eapc_pin_model.pulse(2, 7);
      rd_chk("group disabled", eapc_pkg::IDX_PC_FLAGS, 8'h00);
      wr(eapc_pkg::IDX_PC_EN, 8'h0f);
      for (int k = 0; k < 4; k++) begin
         wr(msk[k], 8'h80);
         u_eapc_pin_model.pulse(2, 8 * k + 6);
         rd_chk("masked pin", eapc_pkg::IDX_PC_FLAGS, 8'h00);
         u_eapc_pin_model.pulse(2, 8 * k + 7);
         rd_chk("group flag", eapc_pkg::IDX_PC_FLAGS, 8'(8'h01 << k));
         if (k == 3) begin
            wr(eapc_pkg::IDX_PC_FLAGS, 8'h08);
            rd_chk("group3 read only", eapc_pkg::IDX_PC_FLAGS, 8'h08);
         end
         wait_irq(3'(4 + k));
         ack();
         rd_chk("group flag entry", eapc_pkg::IDX_PC_FLAGS, 8'h00);
      end
   endtask
   // sleep with lines disabled cuts buffers; line 1 falls and flags
   task automatic t_sleep();
      wr(eapc_pkg::IDX_SENSE, 8'h08);
      sleep_req <= 1'b1;
      wait_clk(5);
      check("buffers off", buf_off, 4'hf);
      rd_chk("sleep flag", eapc_pkg::IDX_EXT_FLAGS, 8'h02);
      sleep_req <= 1'b0;
      wait_clk(5);
      check("buffers on", buf_off, 4'h0);
      wr(eapc_pkg::IDX_EXT_FLAGS, 8'h0f);
   endtask
   // clock enable low: a group-0 pin pulse must leave no trace
   task automatic t_freeze();
      pclk_en <= 1'b0;
      u_eapc_pin_model.pulse(2, 7);
      check("irq while frozen", irq, 1'b0);
      pclk_en <= 1'b1;
      rd_chk("flag after freeze", eapc_pkg::IDX_PC_FLAGS, 8'h00);
   endtask

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h000;
      pwdata    = 32'h0;
      sleep_req = 1'b0;
      irq_ack   = 1'b0;
      pclk_en   = 1'b1;
      wait_clk(4);
      presetn <= 1'b1;
      // detectors settle before any pin activity
      wait_clk(4);
      t_regs();
      t_line_edge();
      t_w1c();
      t_level();
      t_redirect();
      t_groups();
      t_sleep();
      t_freeze();
      complete_run();
   end
endmodule
